// ---- memory_reclaim_window_decoder.sv ----
// Address classifier, reclaim remapper and graphics window decoder with AXI4-Lite registers.
`timescale 1ns/1ps
module memory_reclaim_window_decoder #(
  parameter int REQ_W = reclaim_decoder_pkg::REQ_ADDR_W
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [7:0]                           s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [7:0]                           s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  input  wire logic                                 req_valid,
  input  wire logic [REQ_W-1:0]                     req_addr,
  input  wire logic                                 req_upstream,
  output logic                                      resp_valid,
  output reclaim_decoder_pkg::target_t              resp_target,
  output logic [reclaim_decoder_pkg::ADDR_W-1:0]    resp_phys_addr,
  output logic                                      resp_remapped,
  output logic                                      resp_dram_direct,
  output logic                                      resp_write_combining_attribute
);
  import reclaim_decoder_pkg::*;

  // Configuration state, all in 1 MB units except the prefetch upper extensions, control bits and hit count.
  logic [11:0]           low_dram_top_q;
  logic [MB_W-1:0]       populated_memory_top_q;
  logic [MB_W-1:0]       remap_window_base_q;
  logic [MB_W-1:0]       remap_window_limit_q;
  logic [11:0]           mem_window_base_q;
  logic [11:0]           mem_window_limit_q;
  logic [11:0]           prefetch_window_base_q;
  logic [11:0]           prefetch_window_limit_q;
  logic [UPPER_W-1:0]    prefetch_upper_base_q;
  logic [UPPER_W-1:0]    prefetch_upper_limit_q;
  logic                  reclaim_en_q;
  logic                  graphics_bridge_command_q;
  logic                  cfg_en_q;
  logic [CFG_SIZE_W-1:0] cfg_size_q;
  logic [11:0]           config_space_base_q;
  logic [3:0]            hit_count_q;

  // Write channel: address and data are latched independently, in either order.
  logic                  aw_held_q;
  logic [7:0]            aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  do_write;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [31:0]           rd_word;
  logic [31:0]           wr_merged;
  logic [31:0]           wr_old;

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                          input logic [31:0] ctl_word,
                                          input logic [31:0] upper_word);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (a)
      OFF_LOW_DRAM_TOP:         r = {20'h00000, low_dram_top_q};
      OFF_POPULATED_TOP:        r = {16'h0000, populated_memory_top_q};
      OFF_REMAP_BASE:           r = {16'h0000, remap_window_base_q};
      OFF_REMAP_LIMIT:          r = {16'h0000, remap_window_limit_q};
      OFF_MEM_WINDOW:           r = {4'h0, mem_window_limit_q, 4'h0, mem_window_base_q};
      OFF_PREFETCH_WINDOW:      r = {4'h0, prefetch_window_limit_q, 4'h0, prefetch_window_base_q};
      OFF_PREFETCH_UPPER_BASE:  r = {28'h0000000, prefetch_upper_base_q};
      OFF_PREFETCH_UPPER_LIMIT: r = {28'h0000000, prefetch_upper_limit_q};
      OFF_CONTROL:              r = ctl_word;
      OFF_CONFIG_SPACE_BASE:    r = {20'h00000, config_space_base_q};
      OFF_UPPER_DRAM_TOP:       r = upper_word;
      OFF_STATUS:               r = {28'h0000000, hit_count_q};
      default:                  r = 32'h00000000;
    endcase
    return r;
  endfunction : reg_read

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_STATUS);
  endfunction : addr_mapped

  // Upper DRAM top is derived, never stored.
  wire logic [MB_W-1:0] upper_dram_top = reclaim_en_q ? remap_window_limit_q
                                                     : populated_memory_top_q;
  wire logic [31:0] ctl_word = {26'h0, cfg_size_q, 1'b0, cfg_en_q,
                                graphics_bridge_command_q, reclaim_en_q};
  wire logic [31:0] upper_word = {16'h0000, upper_dram_top};

  assign do_write  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit    = addr_mapped(aw_addr_q);
  assign rd_hit    = addr_mapped(s_axi_araddr);
  // A process, not an assign, so that it wakes when a register read inside the function changes.
  always_comb begin
    rd_word = reg_read(s_axi_araddr, ctl_word, upper_word);
    wr_old  = reg_read(aw_addr_q, ctl_word, upper_word);
  end
  assign wr_merged = {w_strb_q[3] ? w_data_q[31:24] : wr_old[31:24],
                      w_strb_q[2] ? w_data_q[23:16] : wr_old[23:16],
                      w_strb_q[1] ? w_data_q[15:8]  : wr_old[15:8],
                      w_strb_q[0] ? w_data_q[7:0]   : wr_old[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_held_q      <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      // Ready never waits on arvalid, so a master that raises arvalid first is still served.
      s_axi_arready <= !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_hit ? rd_word : 32'h00000000;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // Register file updates.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_dram_top_q            <= LOW_TOP_RESET;
      populated_memory_top_q    <= 16'h0000;
      remap_window_base_q       <= 16'h0000;
      remap_window_limit_q      <= 16'h0000;
      mem_window_base_q         <= 12'hFFF;
      mem_window_limit_q        <= 12'h000;
      prefetch_window_base_q    <= 12'hFFF;
      prefetch_window_limit_q   <= 12'h000;
      prefetch_upper_base_q     <= 4'hF;
      prefetch_upper_limit_q    <= 4'h0;
      reclaim_en_q              <= 1'b0;
      graphics_bridge_command_q <= 1'b0;
      cfg_en_q                  <= 1'b0;
      cfg_size_q                <= 2'b00;
      config_space_base_q       <= 12'h000;
    end else if (do_write && wr_hit) begin
      unique case (aw_addr_q)
        OFF_LOW_DRAM_TOP:         low_dram_top_q <= wr_merged[11:0];
        OFF_POPULATED_TOP:        populated_memory_top_q <= wr_merged[MB_W-1:0];
        OFF_REMAP_BASE:           remap_window_base_q <= wr_merged[MB_W-1:0];
        OFF_REMAP_LIMIT:          remap_window_limit_q <= wr_merged[MB_W-1:0];
        OFF_MEM_WINDOW: begin
          mem_window_base_q  <= wr_merged[WIN_FIELD_W-1:0];
          mem_window_limit_q <= wr_merged[WIN_LIMIT_LSB +: WIN_FIELD_W];
        end
        OFF_PREFETCH_WINDOW: begin
          prefetch_window_base_q  <= wr_merged[WIN_FIELD_W-1:0];
          prefetch_window_limit_q <= wr_merged[WIN_LIMIT_LSB +: WIN_FIELD_W];
        end
        OFF_PREFETCH_UPPER_BASE:  prefetch_upper_base_q <= wr_merged[UPPER_W-1:0];
        OFF_PREFETCH_UPPER_LIMIT: prefetch_upper_limit_q <= wr_merged[UPPER_W-1:0];
        OFF_CONTROL: begin
          reclaim_en_q              <= wr_merged[CTL_RECLAIM_EN];
          graphics_bridge_command_q <= wr_merged[CTL_MEM_ACCESS];
          cfg_en_q                  <= wr_merged[CTL_CFG_EN];
          cfg_size_q                <= wr_merged[CFG_SIZE_LSB +: CFG_SIZE_W];
        end
        OFF_CONFIG_SPACE_BASE:    config_space_base_q <= wr_merged[11:0];
        default: begin
        end
      endcase
    end
  end

  // Address decode, all in 1 MB units over 36 bits.
  wire logic [MB_W-1:0] a_mb     = req_addr[ADDR_W-1:MB_SHIFT];
  wire logic            too_wide = |req_addr[REQ_W-1:ADDR_W];
  wire logic            above_4g = a_mb >= FOUR_GB_MB;
  wire logic [MB_W-1:0] low_top  = {4'h0, low_dram_top_q};
  wire logic [MB_W-1:0] cap_top  = (upper_dram_top > MAX_DRAM_MB) ? MAX_DRAM_MB
                                                                   : upper_dram_top;
  // Window bounds: base low bits are zero and limit low bits all ones, so a
  // comparison of the megabyte numbers alone is exact.
  wire logic [MB_W-1:0] mw_lo    = {4'h0, mem_window_base_q};
  wire logic [MB_W-1:0] mw_hi    = {4'h0, mem_window_limit_q};
  wire logic [MB_W-1:0] pw_lo    = {prefetch_upper_base_q, prefetch_window_base_q};
  wire logic [MB_W-1:0] pw_hi    = {prefetch_upper_limit_q, prefetch_window_limit_q};
  wire logic            mw_hit   = graphics_bridge_command_q && a_mb >= mw_lo
                                   && a_mb <= mw_hi;
  wire logic            pw_hit   = graphics_bridge_command_q && a_mb >= pw_lo
                                   && a_mb <= pw_hi;
  wire logic            gfx_hit  = mw_hit || pw_hit;
  // Config window size: 256, 128 or 64 MB by size code.
  wire logic [11:0]     cfg_mask = (cfg_size_q == 2'b00) ? 12'hF00
                                 : (cfg_size_q == 2'b01) ? 12'hF80 : 12'hFC0;
  wire logic            cfg_hit  = cfg_en_q && !above_4g
                                   && ((a_mb[11:0] & cfg_mask) == (config_space_base_q & cfg_mask));
  wire logic            remap_hit = reclaim_en_q && above_4g && a_mb >= remap_window_base_q
                                    && a_mb <= remap_window_limit_q;
  wire logic            dram_low = !above_4g && a_mb < low_top;
  wire logic            dram_high = above_4g && a_mb < cap_top;
  // Remapped address: offset into the window added to the low DRAM top.
  wire logic [MB_W-1:0] remap_mb = a_mb - remap_window_base_q + low_top;

  target_t             tgt_d;
  logic [ADDR_W-1:0]   phys_d;
  always_comb begin
    tgt_d  = TGT_HUB;
    phys_d = req_addr[ADDR_W-1:0];
    if (req_upstream && too_wide) begin
      tgt_d = TGT_INVALID;
    end else if (!req_upstream && too_wide) begin
      tgt_d = TGT_HUB;
    end else if (remap_hit) begin
      tgt_d  = TGT_DRAM;
      phys_d = {remap_mb, req_addr[MB_SHIFT-1:0]};
    end else if (dram_low || dram_high) begin
      tgt_d = TGT_DRAM;
    end else if (cfg_hit) begin
      tgt_d = TGT_CONFIG;
    end else if (gfx_hit) begin
      tgt_d = TGT_GRAPHICS;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid                     <= 1'b0;
      resp_target                    <= TGT_NONE;
      resp_phys_addr                 <= '0;
      resp_remapped                  <= 1'b0;
      resp_dram_direct               <= 1'b0;
      resp_write_combining_attribute <= 1'b0;
      hit_count_q                    <= 4'h0;
    end else begin
      resp_valid <= req_valid;
      if (req_valid) begin
        resp_target                    <= tgt_d;
        resp_phys_addr                 <= phys_d;
        resp_remapped                  <= tgt_d == TGT_DRAM && remap_hit;
        resp_dram_direct               <= tgt_d == TGT_DRAM && above_4g;
        resp_write_combining_attribute <= tgt_d == TGT_GRAPHICS && pw_hit && !mw_hit;
        if (tgt_d == TGT_DRAM && remap_hit) begin
          hit_count_q <= hit_count_q + 4'h1;
        end
      end
    end
  end
endmodule : memory_reclaim_window_decoder

// ---- reclaim_decoder_pkg.sv ----
// Package with register map, field layouts and target encodings for the reclaim window decoder.
// Behaviour
// - Upstream graphics-port or hub-link accesses above 36 address bits are invalid cycles.
// - Populated memory top holds total installed memory, not the highest address.
// - Reclaim disabled: upper DRAM top equals populated memory top.
// - Reclaim enabled: upper DRAM top equals remap window limit.
// - Low DRAM top holds only address bits 31:20, within first 4 GB.
// - Decoder supports up to 16 GB of physical DRAM.
// - Addresses from 4 GB to upper DRAM top count as directly accessible DRAM.
// - DRAM between low DRAM top and 4 GB is remapped to equal logical range.
// - Remap window addresses translate to DRAM starting at low DRAM top.
// - Accesses hitting ordinary or prefetchable window route to the graphics port.
// - Upper twelve bits of window base and limit map to address bits 31:20.
// - Window base low bits read as zero, limit low bits as ones: 1 MB granularity.
// - Window hit is inclusive at both base and limit.
// - Windows decode only while graphics bridge memory access enable is set.
// - Prefetchable window has upper base and limit extensions for 36-bit MMIO.
// - Config space base defines programmable-size range; software avoids conflicts.
// - Addresses from 1 MB to low DRAM top go to main memory.
// - Unclaimed addresses between low DRAM top and 4 GB go to the hub link.
package reclaim_decoder_pkg;
  localparam int ADDR_W    = 36;
  localparam int REQ_ADDR_W = 40;
  localparam int MB_W      = 16;
  localparam int MB_SHIFT  = 20;

  localparam logic [7:0] OFF_LOW_DRAM_TOP      = 8'h00;
  localparam logic [7:0] OFF_POPULATED_TOP     = 8'h04;
  localparam logic [7:0] OFF_REMAP_BASE        = 8'h08;
  localparam logic [7:0] OFF_REMAP_LIMIT       = 8'h0C;
  localparam logic [7:0] OFF_MEM_WINDOW        = 8'h10;
  localparam logic [7:0] OFF_PREFETCH_WINDOW   = 8'h14;
  localparam logic [7:0] OFF_PREFETCH_UPPER_BASE  = 8'h18;
  localparam logic [7:0] OFF_PREFETCH_UPPER_LIMIT = 8'h1C;
  localparam logic [7:0] OFF_CONTROL           = 8'h20;
  localparam logic [7:0] OFF_CONFIG_SPACE_BASE = 8'h24;
  localparam logic [7:0] OFF_UPPER_DRAM_TOP    = 8'h28;
  localparam logic [7:0] OFF_STATUS            = 8'h2C;

  localparam int CTL_RECLAIM_EN  = 0;
  localparam int CTL_MEM_ACCESS  = 1;
  localparam int CTL_CFG_EN      = 2;
  localparam int CFG_SIZE_LSB    = 4;
  localparam int CFG_SIZE_W      = 2;
  localparam int WIN_LIMIT_LSB   = 16;
  localparam int WIN_FIELD_W     = 12;
  localparam int UPPER_W         = 4;

  localparam logic [11:0] LOW_TOP_RESET  = 12'h000;
  localparam logic [15:0] ONE_MB_UNIT    = 16'h0001;
  localparam logic [15:0] FOUR_GB_MB     = 16'h1000;
  localparam logic [15:0] MAX_DRAM_MB    = 16'h4000;
  localparam logic [19:0] LOW_ZEROS      = 20'h00000;
  localparam logic [19:0] LOW_ONES       = 20'hFFFFF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TGT_NONE     = 3'b000,
    TGT_DRAM     = 3'b001,
    TGT_GRAPHICS = 3'b010,
    TGT_HUB      = 3'b011,
    TGT_CONFIG   = 3'b100,
    TGT_INVALID  = 3'b101
  } target_t;
endpackage : reclaim_decoder_pkg

// ---- requester_model.sv ----
// Requester model standing in for the processor bus and the upstream ports.
`timescale 1ns/1ps
module requester_model #(
  parameter int REQ_W = reclaim_decoder_pkg::REQ_ADDR_W
) (
  input  wire logic             aclk,
  output logic                  req_valid,
  output logic [REQ_W-1:0]      req_addr,
  output logic                  req_upstream
);
  initial begin
    req_valid    = 1'b0;
    req_addr     = '0;
    req_upstream = 1'b0;
  end
  // One request per call; successive calls land on successive edges.
  task automatic issue(input logic [REQ_W-1:0] a, input logic up);
    @(posedge aclk);
    req_valid    <= 1'b1;
    req_addr     <= a;
    req_upstream <= up;
  endtask : issue
  // Idle lines show the inverse of the last request so stale values never match.
  task automatic idle();
    @(posedge aclk);
    req_valid    <= 1'b0;
    req_addr     <= ~req_addr;
    req_upstream <= ~req_upstream;
  endtask : idle
endmodule : requester_model

// ---- reclaim_decoder_sva.sv ----
// Concurrent checks on the decoder response and register bus ports.
`timescale 1ns/1ps
module reclaim_decoder_sva
  import reclaim_decoder_pkg::*;
#(
  parameter int REQ_W = 40
) (
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          req_valid,
  input wire logic [REQ_W-1:0]              req_addr,
  input wire logic                          req_upstream,
  input wire logic                          resp_valid,
  input wire reclaim_decoder_pkg::target_t  resp_target,
  input wire logic [35:0]                   resp_phys_addr,
  input wire logic                          resp_remapped,
  input wire logic                          resp_dram_direct,
  input wire logic                          resp_write_combining_attribute
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RESP_ONE_CYCLE: assert property (req_valid |=> resp_valid)
    else $error("response did not follow request by one cycle");
  AST_RESP_HOLD: assert property (!req_valid |=> !resp_valid && $stable(resp_target) &&
    $stable(resp_phys_addr)) else $error("response changed without a request");
  AST_BEYOND_UPSTREAM: assert property (req_valid && req_upstream &&
    req_addr[REQ_W-1:36] != '0 |=> resp_target == TGT_INVALID)
    else $error("upstream access beyond 36 bits not invalid");
  AST_BEYOND_PROC: assert property (req_valid && !req_upstream &&
    req_addr[REQ_W-1:36] != '0 |=> resp_target == TGT_HUB)
    else $error("processor access beyond 36 bits not sent to hub link");
  AST_PASSTHROUGH: assert property (resp_valid && resp_target == TGT_DRAM && !resp_remapped
    |-> resp_phys_addr == 36'($past(req_addr)) && resp_phys_addr[35:34] == 2'b00)
    else $error("direct DRAM address altered or beyond 16 GB");
  AST_REMAP_TARGET: assert property (resp_valid && resp_remapped |->
    resp_target == TGT_DRAM && resp_dram_direct && resp_phys_addr[35:32] == 4'h0)
    else $error("remapped access not to hidden DRAM below 4 GB");
  AST_DIRECT_FLAG: assert property (resp_valid |-> resp_dram_direct ==
    (resp_target == TGT_DRAM && (resp_remapped || resp_phys_addr[35:32] != 4'h0)))
    else $error("direct DRAM indication wrong");
  AST_WC_GRAPHICS: assert property (resp_valid && resp_write_combining_attribute
    |-> resp_target == TGT_GRAPHICS) else $error("write combining outside graphics port");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped before taken");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  COV_REMAP: cover property (resp_valid && resp_remapped);
endmodule : reclaim_decoder_sva

bind memory_reclaim_window_decoder reclaim_decoder_sva #(.REQ_W(REQ_W)) i_reclaim_decoder_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .req_valid(req_valid), .req_addr(req_addr), .req_upstream(req_upstream),
  .resp_valid(resp_valid), .resp_target(resp_target), .resp_phys_addr(resp_phys_addr),
  .resp_remapped(resp_remapped), .resp_dram_direct(resp_dram_direct),
  .resp_write_combining_attribute(resp_write_combining_attribute));

// ---- memory_reclaim_window_decoder_tb.sv ----
// Self-checking bench for the reclaim window decoder.
`timescale 1ns/1ps
module memory_reclaim_window_decoder_tb;
  import reclaim_decoder_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        req_valid, req_upstream, resp_valid, resp_rem, resp_dd, resp_wc;
  logic [39:0] req_addr;
  target_t     resp_target;
  target_t     e_t;
  logic [35:0] resp_phys, e_p;
  logic        e_r, e_d, e_w;
  logic        pend = 1'b0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  memory_reclaim_window_decoder i_memory_reclaim_window_decoder (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req_valid(req_valid), .req_addr(req_addr), .req_upstream(req_upstream),
    .resp_valid(resp_valid), .resp_target(resp_target), .resp_phys_addr(resp_phys),
    .resp_remapped(resp_rem), .resp_dram_direct(resp_dd),
    .resp_write_combining_attribute(resp_wc));
  requester_model i_requester_model (
    .aclk(aclk), .req_valid(req_valid), .req_addr(req_addr), .req_upstream(req_upstream));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // The ceiling is more than ten times the length of the sequence below.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t register value %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_resp();
    n_compared++;
    if (resp_valid !== 1'b1 || resp_target !== e_t || resp_rem !== e_r || resp_dd !== e_d ||
        resp_wc !== e_w || (e_t === TGT_DRAM && resp_phys !== e_p)) begin
      bad_count++;
      $display("[ERR] %0t decode gave target %0d phys %h", $time, resp_target, resp_phys);
    end
  endtask : cmp_resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid && awready !== 1'b1 || wvalid && wready !== 1'b1);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_reg({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp_reg(rdata, ed);
    cmp_reg({30'h0, rresp}, {30'h0, er});
  endtask : rd
  // Requests go out on consecutive edges; each answer is checked as the next one leaves.
  task automatic dec(input logic [39:0] a, input logic u, input target_t t,
                     input logic [35:0] p, input logic r, input logic d, input logic w);
    i_requester_model.issue(a, u);
    #1;
    if (pend) cmp_resp();
    e_t  = t;
    e_p  = p;
    e_r  = r;
    e_d  = d;
    e_w  = w;
    pend = 1'b1;
  endtask : dec
  task automatic flush();
    i_requester_model.idle();
    #1;
    cmp_resp();
    pend = 1'b0;
  endtask : flush

  initial begin
    aresetn = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_LOW_DRAM_TOP, {20'h0, LOW_TOP_RESET}, RESP_OKAY);
    wr(OFF_LOW_DRAM_TOP, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_LOW_DRAM_TOP, 32'h0000_0FFF, RESP_OKAY);
    wr(OFF_LOW_DRAM_TOP, 32'h0000_0C00, RESP_OKAY);
    wr(8'h02, 32'h0000_0123, RESP_SLVERR);
    rd(OFF_LOW_DRAM_TOP, 32'h0000_0C00, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(OFF_POPULATED_TOP, 32'h0000_1400, RESP_OKAY);
    wr(OFF_REMAP_BASE, 32'h0000_1400, RESP_OKAY);
    wr(OFF_REMAP_LIMIT, 32'h0000_17FF, RESP_OKAY);
    wr(OFF_MEM_WINDOW, 32'h0D0F_0D00, RESP_OKAY);
    wr(OFF_PREFETCH_WINDOW, 32'h0E3F_0E00, RESP_OKAY);
    wr(OFF_PREFETCH_UPPER_BASE, 32'h1, RESP_OKAY);
    wr(OFF_PREFETCH_UPPER_LIMIT, 32'h1, RESP_OKAY);
    wr(OFF_CONTROL, 32'h3, RESP_OKAY);
    rd(OFF_UPPER_DRAM_TOP, 32'h0000_17FF, RESP_OKAY);
    dec(40'h00_1000_0000, 1'b0, TGT_DRAM, 36'h0_1000_0000, 0, 0, 0);
    dec(40'h00_BFFF_FFFF, 1'b1, TGT_DRAM, 36'h0_BFFF_FFFF, 0, 0, 0);
    dec(40'h00_C000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h00_D000_0000, 1'b0, TGT_GRAPHICS, 36'h0, 0, 0, 0);
    dec(40'h00_D0FF_FFFF, 1'b1, TGT_GRAPHICS, 36'h0, 0, 0, 0);
    dec(40'h00_D100_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h01_0000_0000, 1'b0, TGT_DRAM, 36'h1_0000_0000, 0, 1, 0);
    dec(40'h01_3FFF_FFFF, 1'b1, TGT_DRAM, 36'h1_3FFF_FFFF, 0, 1, 0);
    dec(40'h01_4000_0000, 1'b0, TGT_DRAM, 36'h0_C000_0000, 1, 1, 0);
    dec(40'h01_7FFF_FFFF, 1'b1, TGT_DRAM, 36'h0_FFFF_FFFF, 1, 1, 0);
    dec(40'h01_8000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h01_E000_0000, 1'b0, TGT_GRAPHICS, 36'h0, 0, 0, 1);
    dec(40'h01_E3FF_FFFF, 1'b1, TGT_GRAPHICS, 36'h0, 0, 0, 1);
    dec(40'h01_E400_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h0F_FFFF_FFFF, 1'b1, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h10_0000_0000, 1'b1, TGT_INVALID, 36'h0, 0, 0, 0);
    dec(40'h10_0000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    flush();
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    dec(40'h00_D000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h01_E000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    flush();
    wr(OFF_CONTROL, 32'h2, RESP_OKAY);
    rd(OFF_UPPER_DRAM_TOP, 32'h0000_1400, RESP_OKAY);
    dec(40'h01_3FFF_FFFF, 1'b0, TGT_DRAM, 36'h1_3FFF_FFFF, 0, 1, 0);
    dec(40'h01_4000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    dec(40'h00_D000_0000, 1'b1, TGT_GRAPHICS, 36'h0, 0, 0, 0);
    flush();
    wr(OFF_POPULATED_TOP, 32'h0000_4800, RESP_OKAY);
    dec(40'h03_FFFF_FFFF, 1'b0, TGT_DRAM, 36'h3_FFFF_FFFF, 0, 1, 0);
    dec(40'h04_0000_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    flush();
    wr(OFF_CONFIG_SPACE_BASE, 32'h0000_0E80, RESP_OKAY);
    wr(OFF_CONTROL, 32'h0000_0026, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0000_0026, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0002, RESP_OKAY);
    dec(40'h00_EBFF_FFFF, 1'b0, TGT_CONFIG, 36'h0, 0, 0, 0);
    dec(40'h00_EC00_0000, 1'b0, TGT_HUB, 36'h0, 0, 0, 0);
    flush();
    give_verdict();
  end
endmodule : memory_reclaim_window_decoder_tb
